// File: hw/ccx_pkg.sv
package ccx_pkg;
  // Instruction kinds presented to the unit
  typedef enum logic [2:0] {
    CCX_OP_NONE = 3'h0,
    CCX_OP_CALL_REL = 3'h1,
    CCX_OP_CALL_ABS = 3'h2,
    CCX_OP_CMP_MEM = 3'h3,
    CCX_OP_CMP_REG = 3'h4
  } ccx_op_t;
  // Relational operators for register compare
  typedef enum logic [1:0] {
    CCX_REL_EQ = 2'h0,
    CCX_REL_LT = 2'h1,
    CCX_REL_GE = 2'h2,
    CCX_REL_NE = 2'h3
  } ccx_relational_operator_t;
  // Operand kind of a compare source or destination
  typedef enum logic [0:0] {
    CCX_KIND_TA = 1'h0,
    CCX_KIND_AC = 1'h1
  } ccx_kind_t;
  // Condition classes of the 7-bit condition field: [6:4] class, [3:2] unit, [1:0] relational_operator
  localparam logic [2:0] CCX_CC_ACC_ZERO = 3'h0;
  localparam logic [2:0] CCX_CC_OVF = 3'h1;
  localparam logic [2:0] CCX_CC_CARRY = 3'h2;
  localparam logic [2:0] CCX_CC_TC1 = 3'h3;
  localparam logic [2:0] CCX_CC_TC2 = 3'h4;
  localparam logic [2:0] CCX_CC_NCARRY = 3'h5;
  localparam int CCX_CC_CLASS_MSB = 6;
  localparam int CCX_CC_CLASS_LSB = 4;
  localparam int CCX_CC_UNIT_MSB = 3;
  localparam int CCX_CC_UNIT_LSB = 2;
  // Absolute call opcode prefix and instruction sizes in bytes
  localparam logic [7:0] CCX_ABS_PREFIX = 8'h69;
  localparam logic [23:0] CCX_SIZE_REL = 24'h000004;
  localparam logic [23:0] CCX_SIZE_ABS = 24'h000005;
  // Cycle counts: taken/not taken
  localparam logic [2:0] CCX_CYC_REL_TAKEN = 3'h6;
  localparam logic [2:0] CCX_CYC_REL_NOT = 3'h5;
  localparam logic [2:0] CCX_CYC_ABS = 3'h5;
  // Stack pointer step and reset values
  localparam logic [15:0] CCX_STACK_STEP = 16'h0001;
  localparam logic [15:0] CCX_SP_RESET = 16'h0000;
  localparam logic [15:0] CCX_SSP_RESET = 16'h0000;
  localparam logic [23:0] CCX_PC_RESET = 24'h000000;
  localparam int CCX_LOOP_BITS = 8;
endpackage

// File: hw/ccx_cond_call_compare_exec.sv
// How it works
// RL1: call only when selected condition is true
// RL2: condition sees flags one cycle late
// RL3: data stack drops one, stores low return
// RL4: system stack drops one, stores loop:high return
// RL5: load target pc, clear control-flow context
// RL6: absolute call takes five cycles always
// RL7: absolute form: 24-bit target, prefix 0110 1001
// RL8: legacy mode zero tests use wide width
// RL9: condition uses overflow, carry, modes, test flags
// RL10: calls refused inside a repeat
// RL11: memory equals signed immediate sets flag
// RL12: compares allowed inside a repeat
// RL13: accumulator versus aux uses low sixteen bits
// RL14: relation true sets flag, else clears
// RL15: unsigned option; aux pairs compare 16 bits
// RL16: accumulator pairs 32 or 40 bits by mode
// RL17: legacy mode accumulator compares act wide
// RL18: register compare happens in execute stage
// RL19: false call keeps stacks, steps pc past it
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module ccx_cond_call_compare_exec
  import ccx_pkg::*;
#(
  parameter int AW = 24, // Program address width
  parameter int DW = 40 // Accumulator width
) (
  input wire logic clk_sys, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic issue, // One-cycle instruction issue strobe
  input wire ccx_pkg::ccx_op_t op, // Instruction kind
  input wire logic [7:0] opcode_prefix, // First opcode byte of absolute call
  input wire logic [6:0] cond_field, // Condition field of a call
  input wire logic [15:0] relative_target_offset, // Signed pc offset
  input wire logic [23:0] absolute_target_address, // Absolute target
  input wire logic in_repeat, // Instruction is a repeat body
  input wire logic [AW-1:0] pc_in, // Address of issued instruction
  input wire logic [CCX_LOOP_BITS-1:0] loop_context, // Loop context bits
  input wire logic [15:0] sp_in, // Data stack pointer load value
  input wire logic [15:0] ssp_in, // System stack pointer load value
  input wire logic sp_load, // Load both stack pointers
  input wire logic [DW-1:0] acc_a, // Accumulator operand a
  input wire logic [DW-1:0] acc_b, // Accumulator operand b
  input wire logic [15:0] ta_a, // Aux or temp operand a
  input wire logic [15:0] ta_b, // Aux or temp operand b
  input wire ccx_pkg::ccx_kind_t src_kind, // Source kind
  input wire ccx_pkg::ccx_kind_t dst_kind, // Destination kind
  input wire ccx_pkg::ccx_relational_operator_t relational_operator, // Relation
  input wire logic unsigned_opt, // Unsigned comparison
  input wire logic tc_sel, // 0 selects flag one, 1 flag two
  input wire logic [15:0] mem_operand, // Data memory operand
  input wire logic [15:0] signed_immediate_constant, // Immediate
  input wire logic [3:0] accumulator_overflow_flag, // Overflow flags
  input wire logic carry, // Carry status
  input wire logic legacy_compat_mode, // Legacy mode bit
  input wire logic wide_accumulator_mode, // Wide mode bit
  input wire logic [DW-1:0] acc_cond_value, // Accumulator under test
  output logic busy, // Multi-cycle call in progress
  output logic refused, // Pulse: call refused in repeat
  output logic [AW-1:0] pc_out, // Program counter
  output logic [15:0] data_stack_pointer, // Data stack pointer
  output logic [15:0] system_stack_pointer, // System stack pointer
  output logic stack_we, // Pulse: stack words valid
  output logic [15:0] data_stack_word, // Word at data stack top
  output logic [15:0] system_stack_word, // Word at system stack top
  output logic ctx_clear, // Pulse: clear control-flow context
  output logic test_condition_flag_one, // Test flag one
  output logic test_condition_flag_two, // Test flag two
  output logic [3:0] ovf_clear // Pulse: overflow flags consumed
);
  import ccx_pkg::*;

  typedef enum logic [1:0] {
    CCX_ST_IDLE = 2'b00,
    CCX_ST_READ = 2'b01,
    CCX_ST_WAIT = 2'b11
  } ccx_state_t;

  // ----------------------------------------
  // Condition inputs seen one cycle late
  // ----------------------------------------
  logic [3:0] ovf_d;
  logic carry_d;
  logic legacy_d;
  logic wide_d;
  logic [DW-1:0] acc_d;
  // One register stage on each condition input port; the test flag copies are delayed in their own block below
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovf_d <= 4'h0;
      carry_d <= 1'b0;
      legacy_d <= 1'b0;
      wide_d <= 1'b0;
      acc_d <= '0;
    end else begin
      ovf_d <= accumulator_overflow_flag; // RL2
      carry_d <= carry;
      legacy_d <= legacy_compat_mode;
      wide_d <= wide_accumulator_mode;
      acc_d <= acc_cond_value;
    end
  end


  // ----------------------------------------
  // Latched call
  // ----------------------------------------
  ccx_state_t state;
  logic [6:0] cc;
  logic is_abs;
  logic [AW-1:0] call_pc;
  logic [AW-1:0] call_target;
  logic [CCX_LOOP_BITS-1:0] call_loop;
  logic [2:0] cyc;
  logic tc1_d;
  logic tc2_d;


  // A call issued while busy outside a repeat body is dropped without a refusal pulse
  wire logic call_issue = issue && (op == CCX_OP_CALL_REL ||
      (op == CCX_OP_CALL_ABS && opcode_prefix == CCX_ABS_PREFIX)); // RL7
  wire logic call_ok = call_issue && !in_repeat && state == CCX_ST_IDLE; // RL10


  // Zero test of an accumulator: 32 bits unless wide or legacy mode
  function automatic logic acc_rel(input logic [DW-1:0] v, input logic wide,
      input logic [1:0] rel);
    logic neg;
    logic zero;
    neg = wide ? v[DW-1] : v[31];
    zero = wide ? (v == '0) : (v[31:0] == 32'h0);
    case (rel)
      2'h0: acc_rel = zero;
      2'h1: acc_rel = neg;
      2'h2: acc_rel = !neg;
      default: acc_rel = !zero;
    endcase
  endfunction


  logic cond_true;
  always_comb begin
    cond_true = 1'b0;
    case (cc[CCX_CC_CLASS_MSB:CCX_CC_CLASS_LSB]) // RL9
      CCX_CC_ACC_ZERO: cond_true = acc_rel(acc_d, wide_d || legacy_d, cc[1:0]); // RL8
      CCX_CC_OVF: cond_true = ovf_d[cc[CCX_CC_UNIT_MSB:CCX_CC_UNIT_LSB]];
      CCX_CC_CARRY: cond_true = carry_d;
      CCX_CC_NCARRY: cond_true = !carry_d;
      CCX_CC_TC1: cond_true = tc1_d;
      CCX_CC_TC2: cond_true = tc2_d;
      // Unused classes never call
      default: cond_true = 1'b0;
    endcase
  end


  wire logic [AW-1:0] ret_addr = call_pc + (is_abs ? CCX_SIZE_ABS : CCX_SIZE_REL);
  wire logic [15:0] next_sp = data_stack_pointer - CCX_STACK_STEP;
  wire logic [15:0] next_ssp = system_stack_pointer - CCX_STACK_STEP;


  // ----------------------------------------
  // Call sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= CCX_ST_IDLE;
      cc <= 7'h00;
      is_abs <= 1'b0;
      call_pc <= CCX_PC_RESET;
      call_target <= CCX_PC_RESET;
      call_loop <= '0;
      cyc <= 3'h0;
    end else begin
      case (state)
        CCX_ST_IDLE: begin
          if (call_ok) begin
            state <= CCX_ST_READ;
            cc <= cond_field;
            is_abs <= (op == CCX_OP_CALL_ABS);
            call_pc <= pc_in;
            call_loop <= loop_context;
            call_target <= (op == CCX_OP_CALL_ABS) ? absolute_target_address
                : pc_in + {{(AW-16){relative_target_offset[15]}}, relative_target_offset};
          end
        end
        CCX_ST_READ: begin
          state <= CCX_ST_WAIT;
          // Issue and read cycles already consumed two of the total
          if (is_abs) cyc <= CCX_CYC_ABS - 3'h2; // RL6
          else cyc <= (cond_true ? CCX_CYC_REL_TAKEN : CCX_CYC_REL_NOT) - 3'h2;
        end
        CCX_ST_WAIT: begin
          cyc <= cyc - 3'h1;
          // Counter ends at one so the idle edge closes the occupancy
          if (cyc == 3'h1) state <= CCX_ST_IDLE;
        end
        default: state <= CCX_ST_IDLE;
      endcase
    end
  end

  wire logic taken = (state == CCX_ST_READ) && cond_true; // RL1

  // ----------------------------------------
  // Stack pointers and pushed words: pushes in the read stage, pointer loads when idle
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_stack_pointer <= CCX_SP_RESET;
      system_stack_pointer <= CCX_SSP_RESET;
      data_stack_word <= 16'h0000;
      system_stack_word <= 16'h0000;
      stack_we <= 1'b0;
    end else begin
      stack_we <= taken;
      // A false call leaves pointers and pushed words alone
      if (taken) begin
        data_stack_pointer <= next_sp; // RL3
        data_stack_word <= ret_addr[15:0]; // RL3
        system_stack_pointer <= next_ssp; // RL4
        system_stack_word <= {call_loop, ret_addr[23:16]}; // RL4
        // A push outranks a pointer load in the same cycle; the load is lost
      end else if (sp_load && state == CCX_ST_IDLE) begin
        data_stack_pointer <= sp_in;
        system_stack_pointer <= ssp_in;
      end // RL19
    end
  end


  // ----------------------------------------
  // Program counter and context flag clear
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pc_out <= CCX_PC_RESET;
      ctx_clear <= 1'b0;
      ovf_clear <= 4'h0;
    end else begin
      ctx_clear <= taken; // RL5
      ovf_clear <= 4'h0;
      if (state == CCX_ST_READ) begin
        // Taken or not, pc leaves the call in the read stage
        if (cond_true) pc_out <= call_target; // RL5
        else pc_out <= ret_addr; // RL19
        // Testing an overflow flag consumes it
        if (cc[CCX_CC_CLASS_MSB:CCX_CC_CLASS_LSB] == CCX_CC_OVF) begin
          ovf_clear[cc[CCX_CC_UNIT_MSB:CCX_CC_UNIT_LSB]] <= 1'b1; // RL9
        end
      end
    end
  end


  // ----------------------------------------
  // Occupancy and refusal
  // ----------------------------------------
  // Busy falls with the last wait edge so the next call may issue at once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      refused <= 1'b0;
    end else begin
      busy <= (state != CCX_ST_IDLE && !(state == CCX_ST_WAIT && cyc == 3'h1)) || call_ok;
      refused <= call_issue && in_repeat; // RL10
    end
  end


  // ----------------------------------------
  // Compare group, execute stage
  // ----------------------------------------
  logic [DW:0] ca;
  logic [DW:0] cb;
  logic rel_true;
  always_comb begin
    ca = '0;
    cb = '0;
    // One extra bit lets a single unsigned compare serve both options
    if (src_kind == CCX_KIND_AC && dst_kind == CCX_KIND_AC) begin
      if (wide_accumulator_mode || legacy_compat_mode) begin // RL16 RL17
        ca = {unsigned_opt ? 1'b0 : acc_a[DW-1], acc_a};
        cb = {unsigned_opt ? 1'b0 : acc_b[DW-1], acc_b};
      end else begin // RL16
        ca = {{(DW-31){unsigned_opt ? 1'b0 : acc_a[31]}}, acc_a[31:0]};
        cb = {{(DW-31){unsigned_opt ? 1'b0 : acc_b[31]}}, acc_b[31:0]};
      end
    end else begin
      // Mixed or aux pairs: 16 bits, accumulator low half only
      ca[15:0] = (src_kind == CCX_KIND_AC) ? acc_a[15:0] : ta_a; // RL13
      cb[15:0] = (dst_kind == CCX_KIND_AC) ? acc_b[15:0] : ta_b;
      ca[DW:16] = {(DW-15){unsigned_opt ? 1'b0 : ca[15]}}; // RL15
      cb[DW:16] = {(DW-15){unsigned_opt ? 1'b0 : cb[15]}};
    end
    // Sign flip of the extended top bit turns a signed compare unsigned-style
    ca[DW] = ~ca[DW];
    cb[DW] = ~cb[DW];
    // Relations read source against destination
    case (relational_operator)
      CCX_REL_EQ: rel_true = (ca == cb);
      CCX_REL_LT: rel_true = (ca < cb);
      CCX_REL_GE: rel_true = (ca >= cb);
      default: rel_true = (ca != cb);
    endcase
  end


  // ----------------------------------------
  // Test condition flags
  // ----------------------------------------
  // Compares are legal in repeat bodies, so in_repeat is not consulted
  wire logic cmp_mem = issue && op == CCX_OP_CMP_MEM; // RL12
  wire logic cmp_reg = issue && op == CCX_OP_CMP_REG; // RL12
  wire logic cmp_res = cmp_mem ? (mem_operand == signed_immediate_constant) // RL11
      : rel_true; // RL14

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      test_condition_flag_one <= 1'b0;
      test_condition_flag_two <= 1'b0;
    end else if (cmp_mem || cmp_reg) begin // RL18
      if (tc_sel) test_condition_flag_two <= cmp_res; // RL14
      else test_condition_flag_one <= cmp_res; // RL11
    end
  end


  // Flag copies seen by the call condition, one cycle behind
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tc1_d <= 1'b0;
      tc2_d <= 1'b0;
    end else begin
      tc1_d <= test_condition_flag_one; // RL2
      tc2_d <= test_condition_flag_two;
    end
  end

endmodule // ccx_cond_call_compare_exec
`default_nettype wire

// File: verif/ccx_cond_call_compare_exec_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ccx_cond_call_compare_exec_monitor #(
  parameter int AW = 24, // Address width
  parameter int DW = 40 // Accumulator width
) (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic issue, // Issue
  input wire ccx_pkg::ccx_op_t op, // Kind
  input wire logic [7:0] opcode_prefix, // Prefix
  input wire logic [15:0] relative_target_offset, // Offset
  input wire logic [23:0] absolute_target_address, // Target
  input wire logic in_repeat, // Repeat body
  input wire logic [AW-1:0] pc_in, // Call address
  input wire logic sp_load, // Pointer load
  input wire logic tc_sel, // Flag select
  input wire logic [15:0] mem_operand, // Memory word
  input wire logic [15:0] signed_immediate_constant, // Immediate
  input wire logic busy, // Busy
  input wire logic [AW-1:0] pc_out, // Pc
  input wire logic [15:0] data_stack_pointer, // Data pointer
  input wire logic [15:0] system_stack_pointer, // System pointer
  input wire logic stack_we, // Push
  input wire logic [15:0] data_stack_word, // Low word
  input wire logic [15:0] system_stack_word, // High word
  input wire logic ctx_clear, // Context clear
  input wire logic test_condition_flag_one, // Flag one
  input wire logic test_condition_flag_two // Flag two
);
  import ccx_pkg::*;
  // ----------------------------------------
  // Call bookkeeping
  // ----------------------------------------
  logic call_ok, rep_call, cmp_one;
  logic [AW-1:0] tgt_c, ret_c;
  assign call_ok = issue && !in_repeat && !busy && (op == CCX_OP_CALL_REL ||
    (op == CCX_OP_CALL_ABS && opcode_prefix == CCX_ABS_PREFIX));
  assign rep_call = issue && in_repeat && !busy &&
    (op == CCX_OP_CALL_REL || op == CCX_OP_CALL_ABS);
  assign cmp_one = issue && !tc_sel && (op == CCX_OP_CMP_MEM || op == CCX_OP_CMP_REG);
  // Formed at issue, looked up two edges later when the push shows
  assign tgt_c = (op == CCX_OP_CALL_ABS) ? absolute_target_address :
    pc_in + {{8{relative_target_offset[15]}}, relative_target_offset};
  assign ret_c = pc_in + ((op == CCX_OP_CALL_ABS) ? CCX_SIZE_ABS : CCX_SIZE_REL);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  call_busy_a: assert property (call_ok |=> busy)
    else $error("accepted call left busy low");
  refuse_quiet_a: assert property (rep_call |=> !busy ##1 !stack_we)
    else $error("call in repeat body still ran");
  push_target_a: assert property (stack_we |-> pc_out == $past(tgt_c, 2))
    else $error("pc after push is not the target");
  push_words_a: assert property (stack_we |->
    {system_stack_word[7:0], data_stack_word} == $past(ret_c, 2))
    else $error("pushed return words wrong");
  push_ctx_a: assert property (ctx_clear == stack_we)
    else $error("context clear not paired with push");
  ptr_drop_a: assert property (stack_we |->
    data_stack_pointer == $past(data_stack_pointer) - CCX_STACK_STEP &&
    system_stack_pointer == $past(system_stack_pointer) - CCX_STACK_STEP)
    else $error("pointers did not drop by one");
  ptr_still_a: assert property (!stack_we && !$past(sp_load) |->
    $stable(data_stack_pointer) && $stable(system_stack_pointer))
    else $error("pointer moved without a push");
  mem_cmp_a: assert property (issue && op == CCX_OP_CMP_MEM && !tc_sel |=>
    test_condition_flag_one == ($past(mem_operand) == $past(signed_immediate_constant)))
    else $error("memory compare flag wrong");
  flag_keep_a: assert property (cmp_one |=> $stable(test_condition_flag_two))
    else $error("unselected flag changed");
endmodule // ccx_cond_call_compare_exec_monitor
bind ccx_cond_call_compare_exec ccx_cond_call_compare_exec_monitor
  #(.AW(AW), .DW(DW)) u_mon (.*);
`default_nettype wire

// File: verif/ccx_cond_call_compare_exec_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ccx_cond_call_compare_exec_tb_top;
  import ccx_pkg::*;
  typedef struct {logic g, sk, dk; logic [1:0] rl; logic u, w, lg, ts; logic [39:0] a, b; logic e;} ccx_row_t;
  logic clk_sys, rst = 1'b1, issue = 1'b0, in_repeat = 1'b0, sp_load = 1'b0, carry = 1'b0;
  logic unsigned_opt = 1'b0, tc_sel = 1'b0, legacy_compat_mode = 1'b0, wide_accumulator_mode = 1'b0;
  ccx_op_t op = CCX_OP_NONE;
  ccx_kind_t src_kind = CCX_KIND_TA, dst_kind = CCX_KIND_TA;
  ccx_relational_operator_t relational_operator = CCX_REL_EQ;
  logic [7:0] opcode_prefix = CCX_ABS_PREFIX, loop_context = 8'h5A;
  logic [6:0] cond_field = 7'h00;
  logic [15:0] relative_target_offset = 16'hFFF0, sp_in = 16'h0100, ssp_in = 16'h0200;
  logic [15:0] ta_a = 16'h0, ta_b = 16'h0, mem_operand = 16'h0, signed_immediate_constant = 16'h0;
  logic [23:0] absolute_target_address = 24'hABCDEF, pc_in = 24'h12FFFE, pc_out;
  logic [39:0] acc_a = 40'h0, acc_b = 40'h0, acc_cond_value = 40'h0;
  logic [3:0] accumulator_overflow_flag = 4'h0, ovf_clear, ovf_seen;
  logic busy, refused, stack_we, ctx_clear, test_condition_flag_one, test_condition_flag_two;
  logic [15:0] data_stack_pointer, system_stack_pointer, data_stack_word, system_stack_word, esp, essp;
  logic [1:0] tc;
  int fails = 0, checks_done = 0, nbusy, na;
  ccx_row_t r;
  // Columns: reg, src ac, dst ac, relational_operator, unsigned, wide, legacy, flag two, a, b, expected
  ccx_row_t rows [12] = '{'{0, 0, 0, 0, 0, 0, 0, 0, 40'h400, 40'h400, 1},
    '{0, 0, 0, 0, 0, 0, 0, 1, 40'h0, 40'h400, 0}, '{1, 0, 0, 1, 0, 0, 0, 0, 40'hFFFF, 40'h1, 1},
    '{1, 0, 0, 1, 1, 0, 0, 1, 40'hFFFF, 40'h1, 0}, '{1, 1, 0, 0, 0, 0, 0, 0, 40'h280400, 40'h400, 1},
    '{1, 0, 1, 2, 0, 0, 0, 1, 40'h500, 40'h8000000400, 1},
    '{1, 1, 1, 0, 0, 0, 0, 0, 40'h8000280400, 40'h280400, 1},
    '{1, 1, 1, 0, 0, 1, 0, 1, 40'h8000280400, 40'h280400, 0},
    '{1, 1, 1, 0, 0, 0, 1, 0, 40'h8000280400, 40'h280400, 0},
    '{1, 1, 1, 1, 0, 0, 0, 1, 40'h80000000, 40'h0, 1},
    '{1, 1, 1, 1, 1, 0, 0, 1, 40'h1, 40'hFFFFFFFF, 1},
    '{1, 1, 1, 3, 0, 0, 0, 0, 40'h8000000000, 40'h0, 0}};
  ccx_cond_call_compare_exec u_dut (.*);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk_sys);
    rst <= 1'b0;
    tc = 2'b00;
    @(negedge clk_sys);
    chk("reset state", 40'h0, {busy, test_condition_flag_one, test_condition_flag_two,
      stack_we, data_stack_pointer, system_stack_pointer});
    chk("reset pc", 40'h0, pc_out);
  endtask
  // Condition inputs are registered at the issue edge and judged one edge later
  task automatic do_call(input ccx_op_t o, input logic [6:0] cf, input logic cl, input logic tk);
    logic [23:0] tgt = (o == CCX_OP_CALL_ABS) ? 24'hABCDEF : 24'h12FFEE;
    logic [23:0] ret = (o == CCX_OP_CALL_ABS) ? 24'h130003 : 24'h130002;
    int nwe = 0;
    int nctx = 0;
    nbusy = 0;
    @(posedge clk_sys);
    issue <= 1'b1;
    op <= o;
    cond_field <= cf;
    carry <= cl;
    @(posedge clk_sys);
    issue <= 1'b0;
    do begin
      @(negedge clk_sys);
      nbusy += int'(busy === 1'b1);
      nwe += int'(stack_we === 1'b1);
      nctx += int'(ctx_clear === 1'b1);
      ovf_seen = ovf_seen | ovf_clear;
    end while (busy === 1'b1 && nbusy < 20);
    chk("pc_out", tk ? tgt : ret, pc_out);
    chk("data sp", tk ? esp - 16'h0001 : esp, data_stack_pointer);
    chk("system sp", tk ? essp - 16'h0001 : essp, system_stack_pointer);
    chk("pushes", tk, nwe);
    chk("context clears", tk, nctx);
    if (tk) begin
      chk("low word", ret[15:0], data_stack_word);
      chk("high word", {8'h5A, ret[23:16]}, system_stack_word);
      esp = esp - 16'h0001;
      essp = essp - 16'h0001;
    end
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    do_reset(10);
    @(posedge clk_sys);
    sp_load <= 1'b1;
    @(posedge clk_sys);
    sp_load <= 1'b0;
    esp = 16'h0100;
    essp = 16'h0200;
    $display("reset test done");
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clk_sys);
      issue <= 1'b1;
      op <= r.g ? CCX_OP_CMP_REG : CCX_OP_CMP_MEM;
      src_kind <= ccx_kind_t'(r.sk);
      dst_kind <= ccx_kind_t'(r.dk);
      relational_operator <= ccx_relational_operator_t'(r.rl);
      unsigned_opt <= r.u;
      wide_accumulator_mode <= r.w;
      legacy_compat_mode <= r.lg;
      tc_sel <= r.ts;
      in_repeat <= i[0];
      acc_a <= r.a;
      acc_b <= r.b;
      ta_a <= r.a[15:0];
      ta_b <= r.b[15:0];
      mem_operand <= r.a[15:0];
      signed_immediate_constant <= r.b[15:0];
      @(posedge clk_sys);
      issue <= 1'b0;
      in_repeat <= 1'b0;
      @(negedge clk_sys);
      tc[r.ts] = r.e;
      chk("flag one", tc[0], test_condition_flag_one);
      chk("flag two", tc[1], test_condition_flag_two);
    end
    $display("compare table done");
    do_call(CCX_OP_CALL_REL, 7'h20, 1'b1, 1'b1);
    do_call(CCX_OP_CALL_REL, 7'h20, 1'b0, 1'b0);
    do_call(CCX_OP_CALL_ABS, 7'h20, 1'b1, 1'b1);
    na = nbusy;
    do_call(CCX_OP_CALL_ABS, 7'h50, 1'b1, 1'b0);
    chk("abs busy cycles", na, nbusy);
    $display("call test done");
    @(posedge clk_sys);
    acc_cond_value <= 40'h8000000000;
    do_call(CCX_OP_CALL_REL, 7'h00, 1'b0, 1'b1);
    @(posedge clk_sys);
    legacy_compat_mode <= 1'b1;
    do_call(CCX_OP_CALL_REL, 7'h00, 1'b0, 1'b0);
    do_call(CCX_OP_CALL_REL, 7'h03, 1'b0, 1'b1);
    do_call(CCX_OP_CALL_REL, 7'h01, 1'b0, 1'b1);
    do_call(CCX_OP_CALL_REL, 7'h02, 1'b0, 1'b0);
    @(posedge clk_sys);
    accumulator_overflow_flag <= 4'b0100;
    ovf_seen = 4'h0;
    do_call(CCX_OP_CALL_REL, 7'h18, 1'b0, 1'b1);
    chk("overflow consumed", 40'h4, ovf_seen);
    $display("condition test done");
    @(posedge clk_sys);
    issue <= 1'b1;
    op <= CCX_OP_CMP_MEM;
    tc_sel <= 1'b0;
    mem_operand <= 16'h1234;
    signed_immediate_constant <= 16'h1234;
    do_call(CCX_OP_CALL_REL, 7'h30, 1'b0, 1'b1);
    do_call(CCX_OP_CALL_REL, 7'h40, 1'b0, 1'b1);
    $display("flag latency test done");
    // Pass 0: call inside a repeat body; pass 1: absolute call with a bad prefix
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      issue <= 1'b1;
      op <= CCX_OP_CALL_ABS;
      in_repeat <= !k[0];
      opcode_prefix <= k[0] ? 8'h00 : CCX_ABS_PREFIX;
      @(posedge clk_sys);
      issue <= 1'b0;
      in_repeat <= 1'b0;
      na = 0;
      nbusy = 0;
      repeat (4) begin
        @(negedge clk_sys);
        na += int'(refused === 1'b1);
        nbusy += int'(busy === 1'b1) + int'(stack_we === 1'b1);
      end
      chk("refusals", !k[0], na);
      chk("busy or push", 40'h0, nbusy);
      chk("data sp", esp, data_stack_pointer);
    end
    $display("repeat test done");
    @(posedge clk_sys);
    do_reset(2);
    $display("mid-run reset test done");
    test_done();
  end
  initial begin
    #1000000;
    fails++;
    test_done();
  end
endmodule // ccx_cond_call_compare_exec_tb_top
`default_nettype wire
